// file: hw/lcia_top.sv
// Summary of operation
// - optical enable settable, resets on
// - rf enable settable, resets on
// - optical off forces rf off, locks rf writes
// - rf was on: restored with optical
// - rf was off: stays off after restore
// - valid quick-swap reinitialises all configuration
// - preset uses factory optimum omi
// - set uses stored omi offset
// - manual uses attenuator only, no agc
// - wrong type message rejected, nothing changed
// - measurements compared to stored limits
// - limit crossing lights led, reports fault
// - factory crc minor; alarm, cal major
// - flash, boot, hardware errors major red
// - omi and attenuator in half-dB steps
// - video offset 2..5 dB, default 4
// - firmware crc fail halts, blinks red
//
// Purpose: supervisory interlock, quick-swap and alarm logic
// Assumes: synchronous inputs, register port with one-cycle read data
// Notes: offsets in half-dB units; video offset code 0..3 = 2..5 dB
`timescale 1ns/10ps
module lcia_top
    import lcia_pkg::*;
#(
    parameter int NMEAS = 6,
    parameter int MW = 16,
    parameter int BLINK = BLINK_CYCLES
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // quick-swap message from control module
    input wire logic qs_valid_i,
    input wire logic [7:0] qs_type_i,
    input wire logic [7:0] qs_alias_i,
    input wire logic qs_rf_en_i,
    input wire logic qs_opt_en_i,
    input wire logic [1:0] qs_pmode_i,
    input wire logic qs_video_i,
    input wire logic [1:0] qs_vofs_i,
    input wire logic [7:0] qs_omi_i,
    input wire logic [7:0] qs_atten_i,
    // measurements and limit table
    input wire logic [NMEAS*MW-1:0] meas_i,
    input wire logic [NMEAS*MW-1:0] high_lim_i,
    input wire logic [NMEAS*MW-1:0] low_lim_i,
    input wire logic [NMEAS-1:0] high_major_i,
    input wire logic [NMEAS-1:0] low_major_i,
    // integrity and error inputs
    input wire logic crc_factory_err_i,
    input wire logic crc_alarm_err_i,
    input wire logic crc_cal_err_i,
    input wire logic flash_err_i,
    input wire logic boot_err_i,
    input wire logic hw_err_i,
    input wire logic fw_crc_err_i,
    // outputs
    output logic opt_en_o,
    output logic rf_en_o,
    output logic agc_en_o,
    output logic [7:0] rf_level_o,
    output lcia_led_e led_o,
    output logic fault_o,
    output logic halt_o,
    output logic qs_reinit_o
);
    // ----------------------------------------
    // configuration state
    // ----------------------------------------
    logic opt_en, next_opt_en;
    logic rf_req, next_rf_req;
    lcia_pmode_e pmode, next_pmode;
    logic video, next_video;
    logic [1:0] vofs, next_vofs;
    logic [7:0] omi, next_omi;
    logic [7:0] atten, next_atten;
    logic [7:0] alias_q, next_alias;
    logic reinit, next_reinit;
    logic qs_ok;

    // message accepted only on matching type
    assign qs_ok = qs_valid_i && (qs_type_i == OWN_TYPE);

    always_comb
    begin
        next_opt_en = opt_en;
        next_rf_req = rf_req;
        next_pmode = pmode;
        next_video = video;
        next_vofs = vofs;
        next_omi = omi;
        next_atten = atten;
        next_alias = alias_q;
        next_reinit = 1'b0;
        if (qs_ok)
        begin
            // whole configuration from the message
            next_alias = qs_alias_i;
            next_opt_en = qs_opt_en_i;
            next_rf_req = qs_rf_en_i;
            next_pmode = (qs_pmode_i == 2'h3) ? PM_PRESET
                       : lcia_pmode_e'(qs_pmode_i);
            next_video = qs_video_i;
            next_vofs = qs_vofs_i;
            next_omi = qs_omi_i;
            next_atten = qs_atten_i;
            next_reinit = 1'b1;
        end
        else if (wr_i)
        begin
            case (addr_i)
                REG_CTRL:
                begin
                    next_opt_en = wdata_i[CTRL_OPT_BIT];
                    // rf write ignored while optical off; remembered
                    // state then decides restore
                    if (opt_en)
                    begin
                        next_rf_req = wdata_i[CTRL_RF_BIT];
                    end
                end
                REG_MODE:
                begin
                    next_pmode = (wdata_i[1:0] == 2'h3) ? pmode
                               : lcia_pmode_e'(wdata_i[1:0]);
                    next_video = wdata_i[2];
                    next_vofs = wdata_i[5:4];
                end
                REG_OMI: next_omi = wdata_i[7:0];
                REG_ATTEN: next_atten = wdata_i[7:0];
                REG_ALIAS: next_alias = wdata_i[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            opt_en <= RST_OPT_EN;
            rf_req <= RST_RF_EN;
            pmode <= PM_PRESET;
            video <= 1'b1;
            vofs <= RST_VOFS;
            omi <= RST_OMI;
            atten <= RST_ATTEN;
            alias_q <= 8'h00;
            reinit <= 1'b0;
        end
        else
        begin
            opt_en <= next_opt_en;
            rf_req <= next_rf_req;
            pmode <= next_pmode;
            video <= next_video;
            vofs <= next_vofs;
            omi <= next_omi;
            atten <= next_atten;
            alias_q <= next_alias;
            reinit <= next_reinit;
        end
    end

    // ----------------------------------------
    // rf level
    // ----------------------------------------
    logic [7:0] next_level;
    logic [7:0] vid_drop;
    logic next_agc;

    always_comb
    begin
        // offset code 0..3 means 2..5 dB, in half-dB units
        vid_drop = video ? (8'(vofs) + 8'h2) << 1 : 8'h00;
        next_agc = 1'b1;
        case (pmode)
            PM_PRESET: next_level = FACTORY_OMI - vid_drop;
            PM_SET: next_level = FACTORY_OMI + omi - vid_drop;
            PM_MANUAL:
            begin
                next_level = atten;
                next_agc = 1'b0;
            end
            default: next_level = FACTORY_OMI;
        endcase
    end

    // ----------------------------------------
    // alarms
    // ----------------------------------------
    logic [NMEAS-1:0] hi, lo;
    logic major, minor, next_fault;
    lcia_led_e next_led;
    logic blink;

    genvar g;
    generate
        for (g = 0; g < NMEAS; g++)
        begin : g_chk
            lcia_lim_chk #(.W(MW)) u_chk (
                .clock_i(clock_i),
                .reset_n_i(reset_n_i),
                .meas_i(meas_i[g*MW +: MW]),
                .high_i(high_lim_i[g*MW +: MW]),
                .low_i(low_lim_i[g*MW +: MW]),
                .high_o(hi[g]),
                .low_o(lo[g])
            );
        end
    endgenerate

    lcia_blink #(.HALF(BLINK)) u_blink (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .phase_o(blink)
    );

    always_comb
    begin
        major = |(hi & high_major_i) || |(lo & low_major_i)
              || crc_alarm_err_i || crc_cal_err_i
              || flash_err_i || boot_err_i || hw_err_i;
        minor = |(hi & ~high_major_i) || |(lo & ~low_major_i)
              || crc_factory_err_i;
        next_fault = major || minor;
        if (major)
            next_led = LED_RED;
        else if (minor)
            next_led = LED_YELLOW;
        else
            next_led = LED_GREEN;
        if (fw_crc_err_i || halt_o)
            next_led = blink ? LED_RED : LED_OFF;
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    logic [31:0] next_rdata;

    always_comb
    begin
        next_rdata = 32'h0;
        if (rd_i)
        begin
            case (addr_i)
                REG_CTRL: next_rdata = {30'h0, rf_req, opt_en};
                REG_MODE: next_rdata = {26'h0, vofs, 1'b0, video, pmode};
                REG_OMI: next_rdata = {24'h0, omi};
                REG_ATTEN: next_rdata = {24'h0, atten};
                REG_ALIAS: next_rdata = {24'h0, alias_q};
                REG_STATUS: next_rdata = {25'h0, halt_o, fault_o,
                                          rf_en_o, led_o, major, minor};
                REG_RFLVL: next_rdata = {24'h0, rf_level_o};
                REG_LIMIT: next_rdata = {16'h0, 16'(hi)};
                REG_MEAS: next_rdata = {16'h0, 16'(lo)};
                REG_TYPE: next_rdata = {24'h0, OWN_TYPE};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            opt_en_o <= RST_OPT_EN;
            rf_en_o <= RST_RF_EN;
            agc_en_o <= 1'b1;
            rf_level_o <= FACTORY_OMI;
            led_o <= LED_GREEN;
            fault_o <= 1'b0;
            halt_o <= 1'b0;
            qs_reinit_o <= 1'b0;
            rdata_o <= 32'h0;
        end
        else
        begin
            opt_en_o <= opt_en;
            rf_en_o <= opt_en && rf_req && !halt_o;
            agc_en_o <= next_agc;
            rf_level_o <= next_level;
            led_o <= next_led;
            fault_o <= next_fault;
            halt_o <= halt_o || fw_crc_err_i;
            qs_reinit_o <= reinit;
            rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_rf_interlock: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        !opt_en |=> !rf_en_o)
        else $error("rf on while optical off");

    a_rf_restore: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (opt_en && rf_req && !halt_o) |=> rf_en_o)
        else $error("rf not restored");

    a_rf_lock: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (!opt_en && !qs_ok) |=> (rf_req == $past(rf_req)))
        else $error("rf changed while locked");

    a_qs_reject: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (qs_valid_i && qs_type_i != OWN_TYPE && !wr_i)
        |=> $stable(alias_q) && $stable(omi) && !reinit)
        else $error("foreign message applied");

    a_qs_apply: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        qs_ok |=> (omi == $past(qs_omi_i)) ##1 qs_reinit_o)
        else $error("message not applied");

    a_manual_noagc: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (pmode == PM_MANUAL) |=> (!agc_en_o && rf_level_o == $past(atten)))
        else $error("manual mode level wrong");

    a_led_major: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (major && !fw_crc_err_i && !halt_o) |=> led_o == LED_RED)
        else $error("major not red");

    a_fault_report: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        (crc_factory_err_i && !major) |=> fault_o)
        else $error("fault not reported");

    a_halt_sticky: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        fw_crc_err_i |=> halt_o ##1 (halt_o && !rf_en_o))
        else $error("halt not held");
endmodule

// file: hw/lcia_pkg.sv
// Purpose: shared constants for the laser control, interlock and alarm block
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes: register offsets are word indexes on the plain register port
package lcia_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_OMI = 4'h2;
    localparam logic [3:0] REG_ATTEN = 4'h3;
    localparam logic [3:0] REG_ALIAS = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_RFLVL = 4'h6;
    localparam logic [3:0] REG_LIMIT = 4'h7;
    localparam logic [3:0] REG_MEAS = 4'h8;
    localparam logic [3:0] REG_TYPE = 4'h9;
    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int CTRL_OPT_BIT = 0;
    localparam int CTRL_RF_BIT = 1;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic RST_OPT_EN = 1'b1;
    localparam logic RST_RF_EN = 1'b1;
    localparam logic [1:0] RST_VOFS = 2'h2;
    localparam logic [7:0] RST_OMI = 8'h00;
    localparam logic [7:0] RST_ATTEN = 8'h00;
    // factory optimum omi, half-dB units; value is a plain default
    localparam logic [7:0] FACTORY_OMI = 8'h40;
    // own module type; value is arbitrary
    localparam logic [7:0] OWN_TYPE = 8'h5a;
    // blink half period in cycles
    localparam int BLINK_TIME_MS = 250;
    localparam int CLK_MHZ = 250;
    localparam int BLINK_CYCLES = BLINK_TIME_MS * 1000 * CLK_MHZ;
    // ----------------------------------------
    // enumerations
    // ----------------------------------------
    typedef enum logic [1:0] {
        PM_PRESET,
        PM_SET,
        PM_MANUAL
    } lcia_pmode_e;
    typedef enum logic [1:0] {
        LED_OFF,
        LED_GREEN,
        LED_YELLOW,
        LED_RED
    } lcia_led_e;
endpackage

// file: hw/lcia_lim_chk.sv
// Purpose: compares one measurement with a high and a low limit
// Assumes: unsigned measurements
// Notes: one instance per monitored parameter
`timescale 1ns/10ps
module lcia_lim_chk
    import lcia_pkg::*;
#(
    parameter int W = 16
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // measurement and limits
    input wire logic [W-1:0] meas_i,
    input wire logic [W-1:0] high_i,
    input wire logic [W-1:0] low_i,
    // result
    output logic high_o,
    output logic low_o
);
    logic next_high;
    logic next_low;

    always_comb
    begin
        next_high = meas_i > high_i;
        next_low = meas_i < low_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            high_o <= 1'b0;
            low_o <= 1'b0;
        end
        else
        begin
            high_o <= next_high;
            low_o <= next_low;
        end
    end
endmodule

// file: hw/lcia_blink.sv
// Purpose: free-running blink toggle for the status LED
// Assumes: half period given in cycles
// Notes: toggles every HALF cycles
`timescale 1ns/10ps
module lcia_blink
    import lcia_pkg::*;
#(
    parameter int HALF = BLINK_CYCLES
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // blink phase
    output logic phase_o
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_phase;

    always_comb
    begin
        next_count = count + 32'h1;
        next_phase = phase_o;
        if (count >= 32'(HALF - 1))
        begin
            next_count = 32'h0;
            next_phase = !phase_o;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            count <= 32'h0;
            phase_o <= 1'b0;
        end
        else
        begin
            count <= next_count;
            phase_o <= next_phase;
        end
    end
endmodule

// file: bench/lcia_ctrl_model.sv
// Purpose: behavioural shelf control module offering quick-swap messages
// Assumes: bench calls send right after a rising clock edge
// Notes: fields are zero before the first message, then carry inverted data while none is offered
`timescale 1ns/10ps
module lcia_ctrl_model
    import lcia_pkg::*;
(
    // clock
    input wire logic clock_i,
    // quick-swap message
    output logic qs_valid_o,
    output logic [7:0] qs_type_o,
    output logic [7:0] qs_alias_o,
    output logic qs_rf_en_o,
    output logic qs_opt_en_o,
    output logic [1:0] qs_pmode_o,
    output logic qs_video_o,
    output logic [1:0] qs_vofs_o,
    output logic [7:0] qs_omi_o,
    output logic [7:0] qs_atten_o
);
    initial
    begin
        qs_valid_o = 1'b0;
        {qs_type_o, qs_alias_o, qs_rf_en_o, qs_opt_en_o, qs_pmode_o} = '0;
        {qs_video_o, qs_vofs_o, qs_omi_o, qs_atten_o} = '0;
    end

    // gap gives a slow or prompt sender
    task automatic send(input int gap, input logic [7:0] ty,
        input logic [7:0] al, input logic rf, input logic op,
        input logic [1:0] pm, input logic vi, input logic [1:0] vo,
        input logic [7:0] om, input logic [7:0] at);
        repeat (gap) @(posedge clock_i);
        {qs_type_o, qs_alias_o} <= {ty, al};
        {qs_rf_en_o, qs_opt_en_o} <= {rf, op};
        {qs_pmode_o, qs_video_o, qs_vofs_o} <= {pm, vi, vo};
        {qs_omi_o, qs_atten_o} <= {om, at};
        qs_valid_o <= 1'b1;
        @(posedge clock_i);
        qs_valid_o <= 1'b0;
        {qs_type_o, qs_alias_o, qs_rf_en_o, qs_opt_en_o} <= ~{ty, al, rf, op};
        {qs_pmode_o, qs_video_o, qs_vofs_o} <= ~{pm, vi, vo};
        {qs_omi_o, qs_atten_o} <= ~{om, at};
        @(posedge clock_i);
    endtask
endmodule

// file: bench/test_laser_control_interlock_alarm.sv
// Purpose: self-checking bench for the interlock, quick-swap and alarm block
// Assumes: blink half period shortened to 4 cycles
// Notes: driver queues expectations, a negedge monitor compares them
`timescale 1ns/10ps
module test_laser_control_interlock_alarm
    import lcia_pkg::*;
;
    typedef struct {int s; logic [31:0] v; logic [31:0] m;} lcia_note_s;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic qs_valid, qs_rf, qs_opt, qs_video;
    logic [7:0] qs_type, qs_alias, qs_omi, qs_atten;
    logic [1:0] qs_pmode, qs_vofs;
    logic [95:0] meas = {6{16'h4000}};
    logic [95:0] hi = {6{16'h8000}};
    logic [95:0] lo = {6{16'h1000}};
    logic [5:0] hmaj = '0, lmaj = '0, errs = '0;
    logic fw = 1'b0;
    logic opt_en_o, rf_en_o, agc_en_o, fault_o, halt_o, qs_reinit_o;
    logic [7:0] rf_level_o;
    lcia_led_e led_o;
    lcia_note_s rq[$], oq[$];
    int failures = 0, num_checks = 0, reinits = 0, cyc = 0, seed = 67;
    logic rd_d = 1'b0;
    logic [1:0] seen = 2'h0;
    string nm[10] = '{"opt_en", "rf_en", "agc_en", "rf_level", "led",
        "fault", "halt", "reinit", "rdata", "blink"};

    initial
    begin
        forever #2 clock_i = ~clock_i;
    end

    lcia_ctrl_model ctl_u (.clock_i(clock_i), .qs_valid_o(qs_valid),
        .qs_type_o(qs_type), .qs_alias_o(qs_alias), .qs_rf_en_o(qs_rf),
        .qs_opt_en_o(qs_opt), .qs_pmode_o(qs_pmode), .qs_video_o(qs_video),
        .qs_vofs_o(qs_vofs), .qs_omi_o(qs_omi), .qs_atten_o(qs_atten));

    lcia_top #(.BLINK(4)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .qs_valid_i(qs_valid), .qs_type_i(qs_type),
        .qs_alias_i(qs_alias), .qs_rf_en_i(qs_rf), .qs_opt_en_i(qs_opt),
        .qs_pmode_i(qs_pmode), .qs_video_i(qs_video), .qs_vofs_i(qs_vofs),
        .qs_omi_i(qs_omi), .qs_atten_i(qs_atten), .meas_i(meas),
        .high_lim_i(hi), .low_lim_i(lo), .high_major_i(hmaj),
        .low_major_i(lmaj), .crc_factory_err_i(errs[0]),
        .crc_alarm_err_i(errs[1]), .crc_cal_err_i(errs[2]),
        .flash_err_i(errs[3]), .boot_err_i(errs[4]), .hw_err_i(errs[5]),
        .fw_crc_err_i(fw), .opt_en_o(opt_en_o), .rf_en_o(rf_en_o),
        .agc_en_o(agc_en_o), .rf_level_o(rf_level_o), .led_o(led_o),
        .fault_o(fault_o), .halt_o(halt_o), .qs_reinit_o(qs_reinit_o));

    // ----------------------------------------
    // monitor
    // ----------------------------------------
    function automatic logic [31:0] pick(input int s);
        case (s)
            0: return {31'h0, opt_en_o};
            1: return {31'h0, rf_en_o};
            2: return {31'h0, agc_en_o};
            3: return {24'h0, rf_level_o};
            4: return {30'h0, led_o};
            5: return {31'h0, fault_o};
            6: return {31'h0, halt_o};
            7: return reinits;
            9: return {30'h0, seen};
            default: return rdata_o;
        endcase
    endfunction

    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input lcia_note_s n);
        logic [31:0] got;
        got = pick(n.s) & n.m;
        num_checks++;
        if (got !== (n.v & n.m))
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm[n.s], n.v & n.m, got);
        end
    endtask

    always @(posedge clock_i)
    begin
        rd_d <= rd_i;
    end

    // one process owns the counters and the timeout
    always @(negedge clock_i)
    begin
        if (qs_reinit_o === 1'b1)
            reinits++;
        if (fw === 1'b1)
            seen = 2'h0;
        else
            seen |= {led_o === LED_RED, led_o === LED_OFF};
        if (rd_d === 1'b1 && rq.size() > 0)
            cmp(rq.pop_front());
        while (oq.size() > 0)
            cmp(oq.pop_front());
        cyc++;
        if (cyc == 8000)
        begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // driver tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic chk(input int s, input logic [31:0] v);
        oq.push_back('{s, v, 32'hffffffff});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        tick(3);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] v,
        input logic [31:0] m);
        addr_i <= a;
        rd_i <= 1'b1;
        rq.push_back('{8, v, m});
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic alm(input logic [15:0] m, input logic h, input logic l,
        input logic [5:0] e, input logic [1:0] x);
        int c;
        logic [95:0] t;
        c = {$random(seed)} % 6;
        t = {6{16'h4000}};
        t[c*16 +: 16] = m;
        meas <= t;
        hmaj <= {6{h}};
        lmaj <= {6{l}};
        errs <= e;
        tick(4);
        chk(4, x);
        chk(5, x != LED_GREEN);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        logic [7:0] om, at, al, ex;
        int k;
        tick(10);
        reset_n_i <= 1'b1;
        tick(2);
        chk(0, 1);
        chk(1, 1);
        chk(4, LED_GREEN);
        rd(REG_MODE, 32'h20, 32'h30);
        rd(4'hf, 32'h0, 32'hffffffff);
        // interlock: rf remembered on, writes while dark ignored
        wr(REG_CTRL, 32'h2);
        chk(0, 0);
        chk(1, 0);
        wr(REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h1);
        chk(1, 1);
        wr(REG_CTRL, 32'h1);
        chk(1, 0);
        wr(REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h2);
        wr(REG_CTRL, 32'h3);
        chk(0, 1);
        chk(1, 0);
        // quick swap, every primary mode, slow and prompt sender
        for (k = 0; k < 3; k++)
        begin
            om = 8'($random(seed)) & 8'h3f;
            at = 8'($random(seed));
            al = 8'($random(seed));
            ctl_u.send(k, OWN_TYPE, al, 1'b1, 1'b1, k[1:0], 1'b0, 2'h0,
                om, at);
            tick(3);
            ex = k == 0 ? FACTORY_OMI : k == 1 ? FACTORY_OMI + om : at;
            chk(3, ex);
            chk(2, k != 2);
            chk(7, k + 1);
            rd(REG_ALIAS, al, 32'hff);
        end
        for (k = 0; k < 4; k++)
        begin
            ctl_u.send(0, OWN_TYPE, al, k[0], 1'b1, k == 3 ? 2'h3 : 2'h0,
                1'b1, k[1:0], om, at);
            tick(3);
            chk(3, FACTORY_OMI - 2 * (k + 2));
            chk(1, k[0]);
        end
        ctl_u.send(0, OWN_TYPE ^ 8'h01, ~al, 1'b0, 1'b0, PM_MANUAL, 1'b0,
            2'h0, om, 8'h00);
        tick(3);
        chk(0, 1);
        chk(1, 1);
        chk(3, FACTORY_OMI - 10);
        chk(7, 7);
        rd(REG_ALIAS, al, 32'hff);
        // register path: omi, mode code 3 keeps the mode, attenuator
        om = 8'($random(seed)) & 8'h3f;
        at = 8'($random(seed));
        wr(REG_OMI, {24'h0, om});
        wr(REG_MODE, 32'h01);
        chk(3, FACTORY_OMI + om);
        wr(REG_MODE, 32'h03);
        chk(3, FACTORY_OMI + om);
        wr(REG_ATTEN, {24'h0, at});
        wr(REG_MODE, 32'h02);
        chk(3, at);
        chk(2, 0);
        rd(REG_MODE, 32'h02, 32'h37);
        rd(REG_OMI, om, 32'hff);
        // limits: strict compare, colour from the table
        alm(16'h8000, 1'b1, 1'b1, 6'h00, LED_GREEN);
        alm(16'h8001, 1'b1, 1'b0, 6'h00, LED_RED);
        alm(16'h8001, 1'b0, 1'b1, 6'h00, LED_YELLOW);
        alm(16'h1000, 1'b1, 1'b1, 6'h00, LED_GREEN);
        alm(16'h0fff, 1'b0, 1'b1, 6'h00, LED_RED);
        alm(16'h0fff, 1'b1, 1'b0, 6'h00, LED_YELLOW);
        for (k = 0; k < 6; k++)
            alm(16'h4000, 1'b0, 1'b0, 6'h01 << k,
                k == 0 ? LED_YELLOW : LED_RED);
        alm(16'h9000, 1'b0, 1'b0, 6'h01, LED_YELLOW);
        alm(16'h9000, 1'b1, 1'b0, 6'h01, LED_RED);
        rd(REG_STATUS, 32'h3f, 32'hffffffff);
        alm(16'h4000, 1'b0, 1'b0, 6'h00, LED_GREEN);
        // firmware check failure halts until reset
        fw <= 1'b1;
        tick(2);
        fw <= 1'b0;
        tick(12);
        chk(6, 1);
        chk(1, 0);
        chk(9, 3);
        reset_n_i <= 1'b0;
        tick(2);
        reset_n_i <= 1'b1;
        tick(2);
        chk(6, 0);
        chk(0, 1);
        tick(2);
        wrap_up();
    end
endmodule
